// >>> gpubk_top.sv
// upper-bank gpio slice: edge polarity for pins 15:8, data, direction and
// interrupt enables for pins 23:16, pending flags, mask and irq output
// assumes a single-cycle register port on I_CLK_SYS; trigger types, the
// enables of pins 15:8 and the polarity of pins 23:16 come from outside
//
// Overview of operation
// - upper byte of polarity register enables both-edge detect, pins 15:8
// - low byte picks high/rising when 1, low/falling when 0, pins 15:8
// - both-edge enable only matters while edge trigger is selected
// - both-edge enable set makes the polarity bit irrelevant in edge mode
// - data bits 7:0 map to pins 23:16, 1 high, 0 low
// - direction 1 drives the pin from the data bit
// - data write on an input pin leaves the pin untouched
// - reading data of an input pin returns its sampled level
// - direction bit 1 output, 0 input; inputs after reset
// - bits 15:8 of data, direction, enable read zero, write zero
// - enable bits 7:0 allow detection on pins 23:16, clear at reset
// - trigger type 1 detects transitions, 0 detects the set level
// - enabled pin meeting its trigger sets its pending flag
// - write one clears pending in edge mode; level mode follows source
`timescale 1ns/1ns
module gpubk_top (
	input  wire logic                   I_CLK_SYS,
	input  wire logic                   I_RESET,
	input  wire logic [31:0]            I_ADDR,
	input  wire logic [15:0]            I_WDATA,
	input  wire logic                   I_WR,
	input  wire logic                   I_RD,
	output logic      [15:0]            O_RDATA,
	input  wire logic [7:0]             I_PIN_MID,
	input  wire logic [7:0]             I_PIN_UP,
	output logic      [7:0]             O_PIN_UP,
	output logic      [7:0]             O_PIN_UP_OE,
	input  wire logic [15:0]            I_TRIG_TYPE,
	input  wire logic [7:0]             I_MID_IRQ_EN,
	input  wire logic [15:0]            I_UP_EDGE_POL,
	output logic      [15:0]            O_IRQ_PEND,
	output logic                        O_IRQ
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic addr_is(
		input gpubk_pkg::gpubk_addr_t a,
		input gpubk_pkg::gpubk_addr_t off
	);
		return a == off;
	endfunction : addr_is

	logic                    hit_pol;
	logic                    hit_data;
	logic                    hit_dir;
	logic                    hit_en;
	logic                    hit_pend;
	logic                    hit_mask;
	logic                    hit_any;

	assign hit_pol  = addr_is(I_ADDR, gpubk_pkg::OFF_EDGE_POL_HI);
	assign hit_data = addr_is(I_ADDR, gpubk_pkg::OFF_UP_DATA);
	assign hit_dir  = addr_is(I_ADDR, gpubk_pkg::OFF_UP_DIR);
	assign hit_en   = addr_is(I_ADDR, gpubk_pkg::OFF_UP_IRQ_EN);
	assign hit_pend = addr_is(I_ADDR, gpubk_pkg::OFF_IRQ_PEND);
	assign hit_mask = addr_is(I_ADDR, gpubk_pkg::OFF_IRQ_MASK);
	assign hit_any  = hit_pol | hit_data | hit_dir | hit_en | hit_pend | hit_mask;

	// ----------------------------------------------------------------
	// write strobes
	// ----------------------------------------------------------------
	logic                    wr_pol;
	logic                    wr_data;
	logic                    wr_dir;
	logic                    wr_en;
	logic                    wr_pend;
	logic                    wr_mask;

	assign wr_pol  = I_WR & hit_pol;
	assign wr_data = I_WR & hit_data;
	assign wr_dir  = I_WR & hit_dir;
	assign wr_en   = I_WR & hit_en;
	assign wr_pend = I_WR & hit_pend;
	assign wr_mask = I_WR & hit_mask;

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	gpubk_pkg::gpubk_word_t  edge_pol_q;
	gpubk_pkg::gpubk_word_t  edge_pol_d;
	gpubk_pkg::gpubk_byte_t  data_q;
	gpubk_pkg::gpubk_byte_t  data_d;
	gpubk_pkg::gpubk_byte_t  dir_q;
	gpubk_pkg::gpubk_byte_t  dir_d;
	gpubk_pkg::gpubk_byte_t  irq_en_q;
	gpubk_pkg::gpubk_byte_t  irq_en_d;
	gpubk_pkg::gpubk_word_t  mask_q;
	gpubk_pkg::gpubk_word_t  mask_d;
	gpubk_pkg::gpubk_word_t  rdata_q;
	gpubk_pkg::gpubk_word_t  rdata_d;
	logic                    irq_q;
	logic                    irq_d;
	gpubk_pkg::gpubk_byte_t  wr_low;

	// the reserved upper byte of the upper-bank registers is never stored
	assign wr_low = I_WDATA[gpubk_pkg::BANK_W-1:0];

	assign edge_pol_d = wr_pol ? I_WDATA : edge_pol_q;

	// a data write only lands on bits whose pin is an output, so turning
	// a pin round later drives the last value written while it drove
	assign data_d = wr_data ? ((wr_low & dir_q) | (data_q & ~dir_q)) : data_q;

	assign dir_d    = wr_dir ? wr_low : dir_q;
	assign irq_en_d = wr_en ? wr_low : irq_en_q;
	assign mask_d   = wr_mask ? I_WDATA : mask_q;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			edge_pol_q <= gpubk_pkg::RST_EDGE_POL;
			data_q     <= gpubk_pkg::RST_DATA;
			dir_q      <= gpubk_pkg::RST_DIR;
			irq_en_q   <= gpubk_pkg::RST_IRQ_EN;
			mask_q     <= gpubk_pkg::RST_MASK;
		end else begin
			edge_pol_q <= edge_pol_d;
			data_q     <= data_d;
			dir_q      <= dir_d;
			irq_en_q   <= irq_en_d;
			mask_q     <= mask_d;
		end
	end

	// ----------------------------------------------------------------
	// detector inputs, lane 7:0 pins 15:8, lane 15:8 pins 23:16
	// ----------------------------------------------------------------
	gpubk_pkg::gpubk_word_t  det_pin;
	gpubk_pkg::gpubk_word_t  det_both;
	gpubk_pkg::gpubk_word_t  det_pol;
	gpubk_pkg::gpubk_word_t  det_en;
	gpubk_pkg::gpubk_word_t  det_clr;
	gpubk_pkg::gpubk_word_t  det_level;
	gpubk_pkg::gpubk_word_t  det_pend;

	assign det_pin  = {I_PIN_UP, I_PIN_MID};
	assign det_both = {I_UP_EDGE_POL[gpubk_pkg::BOTH_LSB +: gpubk_pkg::BANK_W],
	                   edge_pol_q[gpubk_pkg::BOTH_LSB +: gpubk_pkg::BANK_W]};
	assign det_pol  = {I_UP_EDGE_POL[gpubk_pkg::POL_LSB +: gpubk_pkg::BANK_W],
	                   edge_pol_q[gpubk_pkg::POL_LSB +: gpubk_pkg::BANK_W]};
	assign det_en   = {irq_en_q, I_MID_IRQ_EN};

	// clear acts in the write cycle only; writing zero afterwards is the
	// documented cancel and needs no hardware of its own
	assign det_clr  = wr_pend ? I_WDATA : '0;

	// ----------------------------------------------------------------
	// per-pin detectors
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < gpubk_pkg::NDET; g++) begin : g_det
			gpubk_det u_det (
				.i_clk       (I_CLK_SYS),
				.i_reset     (I_RESET),
				.i_pin       (det_pin[g]),
				.i_edge_mode (I_TRIG_TYPE[g]),
				.i_both_en   (det_both[g]),
				.i_pol       (det_pol[g]),
				.i_en        (det_en[g]),
				.i_clr       (det_clr[g]),
				.o_level     (det_level[g]),
				.o_pend      (det_pend[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// both come straight from flops so the pins never glitch on decode
	assign O_PIN_UP    = data_q;
	assign O_PIN_UP_OE = dir_q;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	gpubk_pkg::gpubk_byte_t  up_sampled;
	gpubk_pkg::gpubk_byte_t  data_view;
	gpubk_pkg::gpubk_word_t  rd_pol;
	gpubk_pkg::gpubk_word_t  rd_data;
	gpubk_pkg::gpubk_word_t  rd_dir;
	gpubk_pkg::gpubk_word_t  rd_en;
	gpubk_pkg::gpubk_word_t  rd_mux;

	assign up_sampled = det_level[gpubk_pkg::PEND_UP_LSB +: gpubk_pkg::BANK_W];
	assign data_view  = (data_q & dir_q) | (up_sampled & ~dir_q);

	assign rd_pol  = edge_pol_q;
	assign rd_data = {gpubk_pkg::RSVD_READ, data_view};
	assign rd_dir  = {gpubk_pkg::RSVD_READ, dir_q};
	assign rd_en   = {gpubk_pkg::RSVD_READ, irq_en_q};

	assign rd_mux = hit_pol  ? rd_pol :
	                hit_data ? rd_data :
	                hit_dir  ? rd_dir :
	                hit_en   ? rd_en :
	                hit_pend ? det_pend :
	                hit_mask ? mask_q :
	                gpubk_pkg::RST_RDATA;

	// data stand for one cycle after the strobe and read zero otherwise
	assign rdata_d = (I_RD & hit_any) ? rd_mux : gpubk_pkg::RST_RDATA;

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	// registered to keep the line glitch-free; costs one cycle of latency
	assign irq_d = |(det_pend & mask_q);

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			rdata_q <= gpubk_pkg::RST_RDATA;
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	assign O_RDATA    = rdata_q;
	assign O_IRQ_PEND = det_pend;
	assign O_IRQ      = irq_q;

endmodule : gpubk_top

// >>> gpubk_pkg.sv
// constants shared by the upper-bank gpio slice: offsets, fields, resets
// assumes a 16-bit register port with full 32-bit byte addresses
package gpubk_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W   = 32;
	localparam int unsigned DATA_W   = 16;
	localparam int unsigned BANK_W   = 8;
	localparam int unsigned NDET     = 16;
	localparam int unsigned PRIME_W  = 3;

	typedef logic [DATA_W-1:0] gpubk_word_t;
	typedef logic [BANK_W-1:0] gpubk_byte_t;
	typedef logic [ADDR_W-1:0] gpubk_addr_t;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam gpubk_addr_t OFF_EDGE_POL_HI = 32'h1500108c;
	localparam gpubk_addr_t OFF_UP_DATA     = 32'h150010c0;
	localparam gpubk_addr_t OFF_UP_DIR      = 32'h150010c2;
	localparam gpubk_addr_t OFF_UP_IRQ_EN   = 32'h150010c4;
	localparam gpubk_addr_t OFF_IRQ_PEND    = 32'h15001100;
	localparam gpubk_addr_t OFF_IRQ_MASK    = 32'h15001102;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned POL_LSB     = 0;
	localparam int unsigned BOTH_LSB    = 8;
	localparam int unsigned PIN_LSB     = 0;
	localparam int unsigned PEND_MID_LSB = 0;
	localparam int unsigned PEND_UP_LSB  = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam gpubk_word_t RST_EDGE_POL = 16'h0000;
	localparam gpubk_byte_t RST_DATA     = 8'h00;
	localparam gpubk_byte_t RST_DIR      = 8'h00;
	localparam gpubk_byte_t RST_IRQ_EN   = 8'h00;
	localparam gpubk_word_t RST_MASK     = 16'h0000;
	localparam gpubk_word_t RST_RDATA    = 16'h0000;
	localparam gpubk_byte_t RSVD_READ    = 8'h00;

endpackage : gpubk_pkg

// >>> gpubk_det.sv
// one pin's interrupt detector: synchroniser, edge and level test, pending flag
// assumes the pin is asynchronous to i_clk and all controls are on i_clk
`timescale 1ns/1ns
module gpubk_det (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_pin,
	input  wire logic i_edge_mode,
	input  wire logic i_both_en,
	input  wire logic i_pol,
	input  wire logic i_en,
	input  wire logic i_clr,
	output logic      o_level,
	output logic      o_pend
);

	// ----------------------------------------------------------------
	// synchroniser and history
	// ----------------------------------------------------------------
	logic                              sync1_q;
	logic                              sync2_q;
	logic                              prev_q;
	logic [gpubk_pkg::PRIME_W-1:0]     prime_q;
	logic                              pend_q;
	logic                              pend_d;
	logic                              rise;
	logic                              fall;
	logic                              edge_hit;
	logic                              level_hit;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			prime_q <= '0;
			pend_q  <= 1'b0;
		end else begin
			sync1_q <= i_pin;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			prime_q <= {prime_q[gpubk_pkg::PRIME_W-2:0], 1'b1};
			pend_q  <= pend_d;
		end
	end

	// ----------------------------------------------------------------
	// trigger evaluation
	// ----------------------------------------------------------------
	// edges are suppressed until history holds real samples, so a pin
	// that sits high through reset does not fake a rising edge
	assign rise      = prime_q[gpubk_pkg::PRIME_W-1] & sync2_q & ~prev_q;
	assign fall      = prime_q[gpubk_pkg::PRIME_W-1] & ~sync2_q & prev_q;
	assign edge_hit  = i_both_en ? (rise | fall) : (i_pol ? rise : fall);
	assign level_hit = prime_q[1] & (sync2_q == i_pol);

	// level mode follows the source; edge mode is sticky, set beats clear
	assign pend_d = i_edge_mode ?
		((i_en & edge_hit) | (pend_q & ~i_clr)) :
		(i_en & level_hit);

	assign o_level = sync2_q;
	assign o_pend  = pend_q;

endmodule : gpubk_det

// >>> gpubk_pins.sv
// pin-side model: external devices on pins 15:8 and 23:16
// assumes the bench sets the levels the far side drives
`timescale 1ns/1ns
module gpubk_pins (
	input  wire logic [7:0] i_mid,
	input  wire logic [7:0] i_ext,
	input  wire logic [7:0] i_drv,
	input  wire logic [7:0] i_oe,
	output logic      [7:0] o_mid,
	output logic      [7:0] o_wire
);
	// ------
	// wire resolution
	// ------
	// far side lets go where the chip drives, so no fight on the wire
	assign o_wire = (i_drv & i_oe) | (i_ext & ~i_oe);
	assign o_mid  = i_mid;
endmodule : gpubk_pins

// >>> gpubk_top_sva.sv
// port assertions for the upper-bank gpio slice
// assumes it is bound to gpubk_top
`timescale 1ns/1ns
module gpubk_chk (
	input wire logic        I_CLK_SYS,
	input wire logic        I_RESET,
	input wire logic [31:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic [15:0] O_RDATA,
	input wire logic [7:0]  I_PIN_MID,
	input wire logic [7:0]  I_PIN_UP,
	input wire logic [7:0]  O_PIN_UP,
	input wire logic [7:0]  O_PIN_UP_OE,
	input wire logic [15:0] I_TRIG_TYPE,
	input wire logic [7:0]  I_MID_IRQ_EN,
	input wire logic [15:0] I_UP_EDGE_POL,
	input wire logic [15:0] O_IRQ_PEND,
	input wire logic        O_IRQ
);
	// ------
	// properties
	// ------
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);
	rsvd_read_a: assert property ($past(I_RD) && ($past(I_ADDR) == gpubk_pkg::OFF_UP_DATA
		|| $past(I_ADDR) == gpubk_pkg::OFF_UP_DIR || $past(I_ADDR) == gpubk_pkg::OFF_UP_IRQ_EN)
		|-> O_RDATA[15:8] == 8'h00) else $error("reserved byte not zero");
	dir_write_a: assert property ($past(I_WR) && $past(I_ADDR) == gpubk_pkg::OFF_UP_DIR
		|-> O_PIN_UP_OE == $past(I_WDATA[7:0])) else $error("enable not from direction");
	data_drive_a: assert property ($past(I_WR) && $past(I_ADDR) == gpubk_pkg::OFF_UP_DATA
		|-> (O_PIN_UP & O_PIN_UP_OE) == ($past(I_WDATA[7:0]) & O_PIN_UP_OE))
		else $error("driven pin not written data");
	input_hold_a: assert property ($past(I_WR) && $past(I_ADDR) == gpubk_pkg::OFF_UP_DATA
		|-> ((O_PIN_UP ^ $past(O_PIN_UP)) & ~O_PIN_UP_OE) == 8'h00)
		else $error("input pin drive changed");
	irq_cause_a: assert property (O_IRQ |-> $past(O_IRQ_PEND) != 16'h0000)
		else $error("irq without pending");
	mid_gate_a: assert property ((O_IRQ_PEND[7:0] & ~$past(O_IRQ_PEND[7:0])
		& ~$past(I_MID_IRQ_EN)) == 8'h00) else $error("disabled pin set pending");
	edge_clear_a: assert property (I_WR && I_ADDR == gpubk_pkg::OFF_IRQ_PEND && I_WDATA[0]
		&& I_TRIG_TYPE[0] && $past(I_PIN_MID[0], 2) == $past(I_PIN_MID[0], 3)
		|=> !O_IRQ_PEND[0]) else $error("edge pending not cleared");
	rise_only_a: assert property ($rose(O_IRQ_PEND[8]) && $past(I_TRIG_TYPE[8])
		&& !$past(I_UP_EDGE_POL[8]) && $past(I_UP_EDGE_POL[0])
		|-> $past(I_PIN_UP[0], 3) && !$past(I_PIN_UP[0], 4)) else $error("set without rise");
	both_edge_a: assert property ($rose(O_IRQ_PEND[8]) && $past(I_TRIG_TYPE[8])
		&& $past(I_UP_EDGE_POL[8]) |-> $past(I_PIN_UP[0], 3) != $past(I_PIN_UP[0], 4))
		else $error("set without transition");
endmodule : gpubk_chk

// >>> gpubk_top_tb_top.sv
// self-checking bench for the upper-bank gpio slice with a pin-side model
// assumes gpubk_pkg, gpubk_top, gpubk_pins and gpubk_chk are compiled first
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module gpubk_top_tb_top;
	localparam logic [31:0] A_POL = gpubk_pkg::OFF_EDGE_POL_HI;
	localparam logic [31:0] A_DAT = gpubk_pkg::OFF_UP_DATA;
	localparam logic [31:0] A_DIR = gpubk_pkg::OFF_UP_DIR;
	localparam logic [31:0] A_EN  = gpubk_pkg::OFF_UP_IRQ_EN;
	localparam logic [31:0] A_PND = gpubk_pkg::OFF_IRQ_PEND;
	localparam logic [31:0] A_MSK = gpubk_pkg::OFF_IRQ_MASK;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, irq;
	logic [31:0] addr = 32'h0;
	logic [15:0] wdat = 16'h0, trig = 16'h0, upol = 16'h0, mk = 16'h0, rdat, pend, e_r, tmp;
	logic [15:0] exq[$];
	logic [7:0]  mid = 8'h0, men = 8'h0, ext, pu, oe, wire_up, mid_w;
	logic [7:0]  dir_m = 8'h0, dat_m = 8'h0;
	logic [15:0] cfg[3] = '{16'h0001, 16'h0101, 16'h0000};
	logic [1:0]  hit[3] = '{2'b10, 2'b11, 2'b01};
	int          n_fail = 0, n_checks = 0, cyc = 0, seed;
	gpubk_top dut_u (.I_CLK_SYS(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdat), .I_PIN_MID(mid_w), .I_PIN_UP(wire_up), .O_PIN_UP(pu),
		.O_PIN_UP_OE(oe), .I_TRIG_TYPE(trig), .I_MID_IRQ_EN(men), .I_UP_EDGE_POL(upol),
		.O_IRQ_PEND(pend), .O_IRQ(irq));
	gpubk_pins pin_u (.i_mid(mid), .i_ext(ext), .i_drv(pu), .i_oe(oe), .o_mid(mid_w),
		.o_wire(wire_up));
	// ------
	// clock, watchdog, read monitor
	// ------
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			tally_and_finish();
		end
		rd_d <= rd;
		if (rd_d) begin
			e_r = exq.pop_front();
			`CHK(rdat, e_r)
		end
	end
	// ------
	// bus and pin tasks
	// ------
	task automatic wrt(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrt
	task automatic rdc(input logic [31:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		exq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rdc
	// pin change, then pending and irq check, then clear and cancel
	task automatic ev(input int b, input logic v, input logic e);
		@(posedge clk);
		if (b == 8) ext[0] <= v;
		else mid[0] <= v;
		repeat (5) @(posedge clk);
		`CHK({irq, pend[b]}, {e & mk[b], e})
		rdc(A_PND, {15'h0000, e} << b);
		wrt(A_PND, 16'h0101);
		wrt(A_PND, 16'h0000);
	endtask : ev
	function automatic logic [15:0] dexp();
		return {8'h00, (dat_m & dir_m) | (ext & ~dir_m)};
	endfunction : dexp
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	// ------
	// main sequence
	// ------
	initial begin
		seed = $urandom(77812);
		@(posedge clk);
		ext <= 8'($urandom);
		repeat (5) @(posedge clk);
		rst  <= 1'b0;
		trig <= 16'h0101;
		repeat (3) @(posedge clk);
		`CHK(oe, 8'h00)
		rdc(A_POL, 16'h0000);
		rdc(A_DIR, 16'h0000);
		rdc(A_EN, 16'h0000);
		rdc(A_DAT, dexp());
		dir_m = 8'($urandom) & 8'hfe;
		tmp = 16'($urandom);
		dat_m = tmp[7:0] & dir_m;
		wrt(A_DIR, {8'h00, dir_m});
		wrt(A_DAT, {8'h00, tmp[7:0]});
		repeat (3) @(posedge clk);
		`CHK(pu & dir_m, dat_m)
		rdc(A_DIR, {8'h00, dir_m});
		rdc(A_DAT, dexp());
		wrt(A_EN, 16'h00ff);
		rdc(A_EN, 16'h00ff);
		wrt(A_EN, 16'h0001);
		rdc(32'h150010ce, 16'h0000);
		wrt(A_POL, tmp);
		rdc(A_POL, tmp);
		mk = 16'h0101;
		wrt(A_MSK, mk);
		men <= 8'h01;
		for (int k = 0; k < 3; k++) begin
			wrt(A_POL, cfg[k]);
			ev(0, 1'b1, hit[k][1]);
			ev(0, 1'b0, hit[k][0]);
		end
		mk = 16'h0100;
		wrt(A_MSK, mk);
		wrt(A_POL, 16'h0001);
		ev(0, 1'b1, 1'b1);
		trig <= 16'h0100;
		wrt(A_POL, 16'h0101);
		repeat (4) @(posedge clk);
		`CHK(pend[0], 1'b1)
		wrt(A_PND, 16'h0001);
		@(posedge clk);
		`CHK(pend[0], 1'b1)
		men <= 8'h00;
		repeat (3) @(posedge clk);
		`CHK(pend[0], 1'b0)
		men <= 8'h01;
		mid[0] <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(pend[0], 1'b0)
		upol <= 16'h0001;
		ev(8, 1'b0, 1'b0);
		ev(8, 1'b1, 1'b1);
		upol <= 16'h0100;
		ev(8, 1'b0, 1'b1);
		wrt(A_EN, 16'h0000);
		ev(8, 1'b1, 1'b0);
		tally_and_finish();
	end
endmodule : gpubk_top_tb_top
bind gpubk_top gpubk_chk chk_u (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN_MID(I_PIN_MID),
	.I_PIN_UP(I_PIN_UP), .O_PIN_UP(O_PIN_UP), .O_PIN_UP_OE(O_PIN_UP_OE),
	.I_TRIG_TYPE(I_TRIG_TYPE), .I_MID_IRQ_EN(I_MID_IRQ_EN), .I_UP_EDGE_POL(I_UP_EDGE_POL),
	.O_IRQ_PEND(O_IRQ_PEND), .O_IRQ(O_IRQ));
